// >>> design/isr_pixel_readout_regs.svh
`ifndef ISR_PIXEL_READOUT_REGS_SVH
`define ISR_PIXEL_READOUT_REGS_SVH

// ==========================================================================
// Register offsets
`define ISR_ADDR_CTRL 8'h00
`define ISR_ADDR_WIDTH 8'h04
`define ISR_ADDR_HEIGHT 8'h08
`define ISR_ADDR_HBLANK 8'h0c
`define ISR_ADDR_VBLANK 8'h10
`define ISR_ADDR_EXPOSE 8'h14
`define ISR_ADDR_STATUS 8'h18

// ==========================================================================
// Control word fields
`define ISR_CTRL_SHOW_DARK 0
`define ISR_CTRL_MANUAL_BLACK 1
`define ISR_CTRL_BIN_LO 2
`define ISR_CTRL_BIN_HI 3
`define ISR_CTRL_SNAPSHOT 4
`define ISR_CTRL_BULB 5

// ==========================================================================
// Reset values
`define ISR_DEF_WIDTH 12'ha20
`define ISR_DEF_HEIGHT 12'h798
`define ISR_DEF_HBLANK 12'h1c2
`define ISR_DEF_VBLANK 12'h01a
`define ISR_DEF_EXPOSE 12'h797

// ==========================================================================
// Array geometry
`define ISR_FIRST_COL 12'h010
`define ISR_FIRST_ROW 12'h036
`define ISR_DARK_ROWS 12'h008
`define ISR_DARK_COL_LAST 12'h009
`define ISR_DARK_COL_RIGHT 12'ha3a
`define ISR_ARRAY_COL_LAST 12'habf
`define ISR_DARK_ROW_LAST 12'h031
`define ISR_DARK_ROW_BOTTOM 12'h7d2
`define ISR_ARRAY_ROW_LAST 12'h7d3
`define ISR_IMG_COL_LAST 12'ha2f
`define ISR_IMG_ROW_LAST 12'h7cd

// ==========================================================================
// Serial identifiers and bus answers
`define ISR_ID_SEL_HIGH 8'hba
`define ISR_ID_SEL_LOW 8'h90
`define ISR_RESP_OKAY 2'h0
`define ISR_RESP_SLVERR 2'h2

`endif

// >>> design/isr_pkg.sv
`default_nettype none
package isr_pkg;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_EXPOSE = 6'h02,
    ST_VBLANK = 6'h04,
    ST_DARK = 6'h08,
    ST_ACTIVE = 6'h10,
    ST_STANDBY = 6'h20
  } isr_phase_t;

  typedef enum logic [1:0] {
    COLOR_GREEN_ON_RED_ROW = 2'h0,
    COLOR_RED = 2'h1,
    COLOR_BLUE = 2'h2,
    COLOR_GREEN_ON_BLUE_ROW = 2'h3
  } isr_color_t;

  typedef enum logic [1:0] {
    KIND_DARK = 2'h0,
    KIND_BOUNDARY = 2'h1,
    KIND_IMAGE = 2'h2
  } isr_kind_t;

  typedef struct packed {
    logic show_dark;
    logic manual_black_level_en;
    logic [1:0] row_bin;
    logic snapshot;
    logic bulb;
    logic [11:0] width;
    logic [11:0] height;
    logic [11:0] hblank;
    logic [11:0] vblank;
    logic [11:0] expose;
  } isr_cfg_t;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } isr_axi_in_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } isr_axi_out_t;

  typedef struct packed {
    logic pixclk;
    logic [11:0] data;
    logic frame_active;
    logic line_active;
    logic strobe;
  } isr_pix_bus_t;

  typedef struct packed {
    logic read;
    logic [11:0] col;
    logic [11:0] row;
  } isr_array_t;

endpackage
`default_nettype wire

// >>> design/isr_pixel_readout.sv
// Summary of operation
// - Reset pin low forces defaults; logic resumes when it returns high.
// - Output-disable high puts pixel clock, data and syncs in high impedance.
// - Standby pin low parks the block idle and quiet until high again.
// - In snapshot mode each trigger yields exactly one frame.
// - In bulb mode trigger release ends exposure instead of a count.
// - Serial identifier is BA hex with select high, 90 hex with low.
// - Pixel word is 12 bits, bit 11 most significant.
// - Frame active high over active rows and their horizontal blanking.
// - Line active high only while active pixels are on the bus.
// - Strobe high exactly while the whole array exposes in snapshot.
// - Array spans 2752 columns by 2004 rows from the upper-right corner.
// - Centred 2592 by 1944 image inside boundary ring and dark border.
// - Dark columns 0-9, 2618-2751; dark rows 0-49, 2002-2003.
// - First row alternates green-red and red; second blue and green-blue.
// - Both green sites are kept as distinct colour channels.
// - Default first output pixel is column 16, row 54.
// - Progressive row order with horizontal then vertical blanking.
// - Dark rows read first when shown or manual black level off.
// - Dark row sampling follows row binning; skipping ignored there.
// - No dark rows read otherwise; frame length unchanged.
// - One word per pixel clock; valid only with both syncs high.
// - Eight dark rows remain after binning for every bin, 0 to 3.
`timescale 1ns/100ps
`default_nettype none
`include "isr_pixel_readout_regs.svh"

module isr_pixel_readout import isr_pkg::*; (
  // System
  input wire logic clk_sys,
  input wire logic rst,
  // Register bus
  input wire isr_axi_in_t axi_in,
  output var isr_axi_out_t axi_out,
  // Device pins
  input wire logic reset_n_in,
  input wire logic out_disable_in,
  input wire logic standby_n_in,
  input wire logic trigger_in,
  input wire logic master_clock_in,
  input wire logic slave_id_select_in,
  // Pixel port
  output var isr_pix_bus_t pix_out,
  output logic pix_oe,
  output logic [1:0] pix_color,
  // Array side
  output var isr_array_t array_out,
  output logic [1:0] array_kind,
  input wire logic [11:0] adc_sample_in,
  // Serial identifier
  output logic [7:0] slave_id
);

  // ========================================================================
  // State
  typedef struct packed {
    isr_phase_t state;
    isr_cfg_t cfg;
    logic rstn_s1;
    logic rstn_s2;
    logic oe_s1;
    logic oe_s2;
    logic stby_s1;
    logic stby_s2;
    logic trig_s1;
    logic trig_s2;
    logic trig_d;
    logic mclk_s1;
    logic mclk_s2;
    logic mclk_d;
    logic sel_s1;
    logic sel_s2;
    logic aw_v;
    logic [7:0] aw_a;
    logic w_v;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic b_v;
    logic [1:0] b_r;
    logic r_v;
    logic [31:0] r_d;
    logic [1:0] r_r;
    logic [12:0] col;
    logic [11:0] row;
    logic fv0;
    logic lv0;
    logic [1:0] color0;
    isr_array_t arr;
    logic [1:0] kind;
    isr_pix_bus_t pix;
    logic [1:0] color;
    logic out_en;
    logic [7:0] id;
  } isr_regs_t;

  function automatic isr_cfg_t cfg_default();
    isr_cfg_t c;
    c = '0;
    c.width = `ISR_DEF_WIDTH;
    c.height = `ISR_DEF_HEIGHT;
    c.hblank = `ISR_DEF_HBLANK;
    c.vblank = `ISR_DEF_VBLANK;
    c.expose = `ISR_DEF_EXPOSE;
    return c;
  endfunction

  function automatic isr_regs_t reset_value();
    isr_regs_t r;
    r = '0;
    r.state = ST_VBLANK;
    r.cfg = cfg_default();
    r.stby_s1 = 1'b1;
    r.stby_s2 = 1'b1;
    return r;
  endfunction

  localparam isr_regs_t RESET_VALUE = reset_value();

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic in_range(input logic [11:0] v, input logic [11:0] lo,
                                    input logic [11:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  // Dark border first, then the image window, else boundary ring
  function automatic logic [1:0] pixel_kind(input logic [11:0] c, input logic [11:0] r);
    logic [1:0] k;
    k = KIND_BOUNDARY;
    if (c <= `ISR_DARK_COL_LAST || in_range(c, `ISR_DARK_COL_RIGHT, `ISR_ARRAY_COL_LAST) ||
        r <= `ISR_DARK_ROW_LAST || in_range(r, `ISR_DARK_ROW_BOTTOM, `ISR_ARRAY_ROW_LAST)) begin
      k = KIND_DARK;
    end else if (in_range(c, `ISR_FIRST_COL, `ISR_IMG_COL_LAST) &&
                 in_range(r, `ISR_FIRST_ROW, `ISR_IMG_ROW_LAST)) begin
      k = KIND_IMAGE;
    end
    return k;
  endfunction

  isr_regs_t q;
  isr_regs_t nxt_q;
  logic tick;
  logic trig_rise;
  logic trig_fall;
  logic [12:0] line_len;
  logic line_done;
  logic [11:0] vb_idle;
  logic reading;
  logic [31:0] ctrl_word;

  assign tick = q.mclk_s2 & ~q.mclk_d;
  assign trig_rise = q.trig_s2 & ~q.trig_d;
  assign trig_fall = ~q.trig_s2 & q.trig_d;
  assign line_len = {1'b0, q.cfg.width} + {1'b0, q.cfg.hblank};
  assign line_done = tick && (q.col >= 13'(line_len - 13'h1));
  // Dark rows sit inside vertical blanking, so frame length is unchanged
  assign vb_idle = (q.cfg.vblank > `ISR_DARK_ROWS) ? 12'(q.cfg.vblank - `ISR_DARK_ROWS) :
                   12'h001;
  assign ctrl_word = 32'({q.cfg.bulb, q.cfg.snapshot, q.cfg.row_bin,
                          q.cfg.manual_black_level_en, q.cfg.show_dark});

  // ========================================================================
  // Bus handshakes
  always_comb begin
    axi_out.awready = ~q.aw_v & ~q.b_v;
    axi_out.wready = ~q.w_v & ~q.b_v;
    axi_out.bvalid = q.b_v;
    axi_out.bresp = q.b_r;
    axi_out.arready = ~q.r_v;
    axi_out.rvalid = q.r_v;
    axi_out.rdata = q.r_d;
    axi_out.rresp = q.r_r;
  end

  // ========================================================================
  // Next state
  always_comb begin
    logic [31:0] wv;
    wv = '0;
    reading = 1'b0;
    nxt_q = q;
    nxt_q.rstn_s1 = reset_n_in;
    nxt_q.rstn_s2 = q.rstn_s1;
    nxt_q.oe_s1 = out_disable_in;
    nxt_q.oe_s2 = q.oe_s1;
    nxt_q.stby_s1 = standby_n_in;
    nxt_q.stby_s2 = q.stby_s1;
    nxt_q.trig_s1 = trigger_in;
    nxt_q.trig_s2 = q.trig_s1;
    nxt_q.trig_d = q.trig_s2;
    nxt_q.mclk_s1 = master_clock_in;
    nxt_q.mclk_s2 = q.mclk_s1;
    nxt_q.mclk_d = q.mclk_s2;
    nxt_q.sel_s1 = slave_id_select_in;
    nxt_q.sel_s2 = q.sel_s1;
    nxt_q.id = q.sel_s2 ? `ISR_ID_SEL_HIGH : `ISR_ID_SEL_LOW;
    nxt_q.out_en = ~q.oe_s2;
    // Outputs change with the rising pixel clock, stable at its fall
    nxt_q.pix.pixclk = q.mclk_s2;

    // Write path: address and data taken in either order
    if (axi_in.awvalid && axi_out.awready) begin
      nxt_q.aw_v = 1'b1;
      nxt_q.aw_a = axi_in.awaddr[7:0];
    end
    if (axi_in.wvalid && axi_out.wready) begin
      nxt_q.w_v = 1'b1;
      nxt_q.w_d = axi_in.wdata;
      nxt_q.w_s = axi_in.wstrb;
    end
    if (q.aw_v && q.w_v) begin
      nxt_q.aw_v = 1'b0;
      nxt_q.w_v = 1'b0;
      nxt_q.b_v = 1'b1;
      nxt_q.b_r = `ISR_RESP_OKAY;
      unique case (q.aw_a)
        `ISR_ADDR_CTRL: begin
          wv = wmerge(ctrl_word, q.w_d, q.w_s);
          nxt_q.cfg.show_dark = wv[`ISR_CTRL_SHOW_DARK];
          nxt_q.cfg.manual_black_level_en = wv[`ISR_CTRL_MANUAL_BLACK];
          nxt_q.cfg.row_bin = wv[`ISR_CTRL_BIN_HI:`ISR_CTRL_BIN_LO];
          nxt_q.cfg.snapshot = wv[`ISR_CTRL_SNAPSHOT];
          nxt_q.cfg.bulb = wv[`ISR_CTRL_BULB];
        end
        `ISR_ADDR_WIDTH: nxt_q.cfg.width = 12'(wmerge(32'(q.cfg.width), q.w_d, q.w_s));
        `ISR_ADDR_HEIGHT: nxt_q.cfg.height = 12'(wmerge(32'(q.cfg.height), q.w_d, q.w_s));
        `ISR_ADDR_HBLANK: nxt_q.cfg.hblank = 12'(wmerge(32'(q.cfg.hblank), q.w_d, q.w_s));
        `ISR_ADDR_VBLANK: nxt_q.cfg.vblank = 12'(wmerge(32'(q.cfg.vblank), q.w_d, q.w_s));
        `ISR_ADDR_EXPOSE: nxt_q.cfg.expose = 12'(wmerge(32'(q.cfg.expose), q.w_d, q.w_s));
        `ISR_ADDR_STATUS: nxt_q.b_r = `ISR_RESP_OKAY;
        default: nxt_q.b_r = `ISR_RESP_SLVERR;
      endcase
    end
    if (q.b_v && axi_in.bready) begin
      nxt_q.b_v = 1'b0;
    end

    // Read path
    if (axi_in.arvalid && axi_out.arready) begin
      nxt_q.r_v = 1'b1;
      nxt_q.r_r = `ISR_RESP_OKAY;
      unique case (axi_in.araddr[7:0])
        `ISR_ADDR_CTRL: nxt_q.r_d = ctrl_word;
        `ISR_ADDR_WIDTH: nxt_q.r_d = 32'(q.cfg.width);
        `ISR_ADDR_HEIGHT: nxt_q.r_d = 32'(q.cfg.height);
        `ISR_ADDR_HBLANK: nxt_q.r_d = 32'(q.cfg.hblank);
        `ISR_ADDR_VBLANK: nxt_q.r_d = 32'(q.cfg.vblank);
        `ISR_ADDR_EXPOSE: nxt_q.r_d = 32'(q.cfg.expose);
        `ISR_ADDR_STATUS: nxt_q.r_d = 32'({q.id, q.state, q.pix.strobe,
                                           q.pix.line_active, q.pix.frame_active});
        default: begin
          nxt_q.r_d = '0;
          nxt_q.r_r = `ISR_RESP_SLVERR;
        end
      endcase
    end
    if (q.r_v && axi_in.rready) begin
      nxt_q.r_v = 1'b0;
    end

    // Trigger events are one clock long, so they are seen outside the tick
    if (q.state == ST_IDLE && trig_rise) begin
      nxt_q.state = ST_EXPOSE;
      nxt_q.col = '0;
      nxt_q.row = '0;
    end else if (q.state == ST_EXPOSE && q.cfg.bulb && trig_fall) begin
      nxt_q.state = ST_DARK;
      nxt_q.col = '0;
      nxt_q.row = '0;
    end else if (tick) begin
      nxt_q.col = line_done ? 13'h0 : 13'(q.col + 13'h1);
      unique case (q.state)
        ST_IDLE: begin
          if (!q.cfg.snapshot) begin
            nxt_q.state = ST_VBLANK;
            nxt_q.col = '0;
            nxt_q.row = '0;
          end
        end
        ST_EXPOSE: begin
          if (line_done && !q.cfg.bulb) begin
            nxt_q.row = 12'(q.row + 12'h1);
            if (q.row >= 12'(q.cfg.expose - 12'h1)) begin
              nxt_q.state = ST_DARK;
              nxt_q.row = '0;
            end
          end
        end
        ST_VBLANK: begin
          if (q.cfg.snapshot) begin
            nxt_q.state = ST_IDLE;
          end else if (line_done) begin
            nxt_q.row = 12'(q.row + 12'h1);
            if (q.row >= 12'(vb_idle - 12'h1)) begin
              nxt_q.state = ST_DARK;
              nxt_q.row = '0;
            end
          end
        end
        ST_DARK: begin
          if (line_done) begin
            nxt_q.row = 12'(q.row + 12'h1);
            if (q.row == 12'(`ISR_DARK_ROWS - 12'h1)) begin
              nxt_q.state = ST_ACTIVE;
              nxt_q.row = '0;
            end
          end
        end
        ST_ACTIVE: begin
          if (line_done) begin
            nxt_q.row = 12'(q.row + 12'h1);
            if (q.row >= 12'(q.cfg.height - 12'h1)) begin
              nxt_q.state = q.cfg.snapshot ? ST_IDLE : ST_VBLANK;
              nxt_q.row = '0;
            end
          end
        end
        ST_STANDBY: begin
          nxt_q.state = q.cfg.snapshot ? ST_IDLE : ST_VBLANK;
          nxt_q.col = '0;
          nxt_q.row = '0;
        end
        default: nxt_q.state = ST_VBLANK;
      endcase
    end

    if (!q.stby_s2) begin
      nxt_q.state = ST_STANDBY;
      nxt_q.col = '0;
      nxt_q.row = '0;
    end

    // Position stage: address the array and work out the syncs
    if (tick) begin
      reading = nxt_q.col < {1'b0, q.cfg.width} &&
                (nxt_q.state == ST_ACTIVE || (nxt_q.state == ST_DARK &&
                 (q.cfg.show_dark || !q.cfg.manual_black_level_en)));
      nxt_q.fv0 = nxt_q.state == ST_ACTIVE || (nxt_q.state == ST_DARK && q.cfg.show_dark);
      nxt_q.lv0 = nxt_q.fv0 && nxt_q.col < {1'b0, q.cfg.width};
      // Greens on red rows and blue rows stay separate channels
      nxt_q.color0 = {nxt_q.row[0], nxt_q.col[0]};
      nxt_q.arr.read = reading;
      nxt_q.arr.col = 12'(`ISR_FIRST_COL + nxt_q.col[11:0]);
      nxt_q.arr.row = '0;
      if (nxt_q.state == ST_ACTIVE) begin
        nxt_q.arr.row = 12'(`ISR_FIRST_ROW + nxt_q.row);
      end else if (nxt_q.state == ST_DARK) begin
        // Skipping has no say here; binning widens the sampled stripe
        nxt_q.arr.row = 12'(nxt_q.row * ({10'h0, q.cfg.row_bin} + 12'h1));
      end
      nxt_q.kind = pixel_kind(nxt_q.arr.col, nxt_q.arr.row);
      // Output stage: array answers within the pixel, so data lag one pixel
      nxt_q.pix.frame_active = q.fv0;
      nxt_q.pix.line_active = q.lv0;
      nxt_q.color = q.color0;
      nxt_q.pix.data = (q.fv0 && q.lv0) ? adc_sample_in : 12'h000;
    end
    nxt_q.pix.strobe = nxt_q.state == ST_EXPOSE;

    if (!q.rstn_s2) begin
      nxt_q.cfg = cfg_default();
      nxt_q.state = ST_VBLANK;
      nxt_q.col = '0;
      nxt_q.row = '0;
      nxt_q.fv0 = 1'b0;
      nxt_q.lv0 = 1'b0;
      nxt_q.arr = '0;
      nxt_q.pix.frame_active = 1'b0;
      nxt_q.pix.line_active = 1'b0;
      nxt_q.pix.strobe = 1'b0;
      nxt_q.pix.data = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= RESET_VALUE;
    end else begin
      q <= nxt_q;
    end
  end

  // ========================================================================
  // Outputs
  assign pix_out = q.pix;
  assign pix_oe = q.out_en;
  assign pix_color = q.color;
  assign array_out = q.arr;
  assign array_kind = q.kind;
  assign slave_id = q.id;

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_idle_trigger;
    q.state == ST_IDLE && trig_rise;
  endsequence

  sequence s_bulb_release;
    q.state == ST_EXPOSE && q.cfg.bulb && trig_fall && q.stby_s2 && q.rstn_s2;
  endsequence

  a_pin_reset_defaults: assert property (!q.rstn_s2 |=> q.cfg == cfg_default() &&
      q.state == ST_VBLANK)
    else $error("pin reset did not restore defaults");
  a_oe_high_z: assert property (q.oe_s2 |=> !pix_oe)
    else $error("outputs driven while disabled");
  a_standby_entry: assert property ($fell(q.stby_s2) && q.rstn_s2 |=>
      q.state == ST_STANDBY ##1 !pix_out.strobe)
    else $error("standby not entered");
  a_snapshot_start: assert property (s_idle_trigger and q.stby_s2 && q.rstn_s2 |=>
      q.state == ST_EXPOSE && pix_out.strobe)
    else $error("trigger did not start exposure");
  a_bulb_end: assert property (s_bulb_release |=> q.state == ST_DARK ##1 !pix_out.strobe)
    else $error("bulb release did not end exposure");
  a_slave_id: assert property (q.sel_s2 |=> slave_id == `ISR_ID_SEL_HIGH)
    else $error("wrong serial identifier");
  a_line_in_frame: assert property (pix_out.line_active |-> pix_out.frame_active)
    else $error("line active outside frame");
  a_blank_data: assert property (!(pix_out.frame_active && pix_out.line_active) |->
      pix_out.data == 12'h000)
    else $error("data not blank outside valid pixels");
  a_strobe_expose: assert property (pix_out.strobe |-> q.state == ST_EXPOSE)
    else $error("strobe outside exposure");
  a_first_pixel: assert property ($rose(q.lv0) && q.state == ST_ACTIVE && q.row == 12'h000 |->
      q.arr.col == `ISR_FIRST_COL && q.arr.row == `ISR_FIRST_ROW &&
      q.color0 == COLOR_GREEN_ON_RED_ROW)
    else $error("first pixel misplaced");
  a_dark_rows: assert property (q.state == ST_DARK && line_done && q.row == 12'h007 &&
      q.stby_s2 && q.rstn_s2 |=> q.state == ST_ACTIVE)
    else $error("dark stripe not eight rows");
  a_dark_kind: assert property (q.arr.read && q.state == ST_DARK |-> q.kind == KIND_DARK)
    else $error("dark stripe left the dark border");
  a_no_dark_read: assert property (q.state == ST_DARK && tick && !line_done &&
      !q.cfg.show_dark && q.cfg.manual_black_level_en && q.stby_s2 && q.rstn_s2 |=> !q.arr.read)
    else $error("dark rows read with manual black level");
  a_frame_hblank: assert property (q.state == ST_ACTIVE && tick && !line_done &&
      q.stby_s2 && q.rstn_s2 |=> q.fv0)
    else $error("frame active dropped in active rows");

endmodule // isr_pixel_readout
`default_nettype wire

// >>> tb/isr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Capture host on the far side of the pixel port
module isr_host_model import isr_pkg::*; (
  // Pixel port
  input wire isr_pix_bus_t pix_in,
  input wire logic pix_oe,
  input wire logic [1:0] pix_color,
  // Array side
  input wire isr_array_t array_in,
  output logic [11:0] adc_sample,
  // Capture results
  input wire logic clr,
  output var int n_valid,
  output var int n_frames,
  output logic [11:0] first_data,
  output logic [1:0] first_color
);
  logic fa_q;
  // Sample carries its own address so the first pixel can be traced
  assign adc_sample = {array_in.row[5:0], array_in.col[5:0]};
  always @(negedge pix_in.pixclk or posedge clr) begin
    if (clr) begin
      n_valid <= 0;
      n_frames <= 0;
      fa_q <= 1'b0;
    end else if (pix_oe) begin
      if (pix_in.frame_active && pix_in.line_active) begin
        if (n_valid == 0) begin
          first_data <= pix_in.data;
          first_color <= pix_color;
        end
        n_valid <= n_valid + 1;
      end
      if (fa_q && !pix_in.frame_active) n_frames <= n_frames + 1;
      fa_q <= pix_in.frame_active;
    end
  end
endmodule // isr_host_model
`default_nettype wire

// >>> tb/isr_pixel_readout_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "isr_pixel_readout_regs.svh"
module isr_pixel_readout_tb import isr_pkg::*; ;
  logic clk_sys = 0, rst = 1, reset_n_in = 1, out_disable_in = 0, standby_n_in = 1;
  logic trigger_in = 0, master_clock_in = 0, slave_id_select_in = 0, clr = 1;
  isr_axi_in_t axi_in = '0;
  isr_axi_out_t axi_out;
  isr_pix_bus_t pix_out;
  isr_array_t array_out;
  logic pix_oe;
  logic [1:0] pix_color, first_color, kind;
  logic [11:0] adc, first_data;
  logic [7:0] slave_id, a;
  logic [34:0] exq[$];
  logic [34:0] e;
  int errors = 0, n_tests = 0, seed = 57, n_valid, n_frames, k, m;
  int nexp[4] = '{32, 96, 96, 32};
  logic [7:0] ctl[4] = '{8'h10, 8'h11, 8'h1d, 8'h32};

  always #5 clk_sys = ~clk_sys;
  // Link clock runs free, unrelated in phase to clk_sys
  always #62.5 master_clock_in = ~master_clock_in;

  isr_pixel_readout i_dut (.clk_sys(clk_sys), .rst(rst), .axi_in(axi_in), .axi_out(axi_out),
    .reset_n_in(reset_n_in), .out_disable_in(out_disable_in), .standby_n_in(standby_n_in),
    .trigger_in(trigger_in), .master_clock_in(master_clock_in),
    .slave_id_select_in(slave_id_select_in), .pix_out(pix_out), .pix_oe(pix_oe),
    .pix_color(pix_color), .array_out(array_out), .array_kind(kind), .adc_sample_in(adc),
    .slave_id(slave_id));
  isr_host_model i_host (.pix_in(pix_out), .pix_oe(pix_oe), .pix_color(pix_color),
    .array_in(array_out), .adc_sample(adc), .clr(clr), .n_valid(n_valid),
    .n_frames(n_frames), .first_data(first_data), .first_color(first_color));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task end_of_test;
    if (errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // ==========================================
  // Register bus master, one transfer at a time
  task automatic bus(input logic rd, input logic [7:0] ad, input logic [31:0] d,
                     input logic [1:0] er);
    int i;
    logic ta, tw, tv, tb;
    // Let an edge pass so a strobe lowered by the last call is not raised in the same step
    @(posedge clk_sys);
    exq.push_back({rd, er, d});
    axi_in.arvalid <= rd;
    axi_in.araddr <= {24'h0, ad};
    axi_in.rready <= rd;
    axi_in.awvalid <= !rd;
    axi_in.awaddr <= {24'h0, ad};
    axi_in.wvalid <= !rd;
    axi_in.wdata <= d;
    axi_in.wstrb <= 4'hf;
    axi_in.bready <= !rd;
    for (i = 0; i < 100; i++) begin
      @(negedge clk_sys);
      ta = axi_out.arready;
      tw = axi_out.awready;
      tv = axi_out.wready;
      tb = rd ? axi_out.rvalid : axi_out.bvalid;
      @(posedge clk_sys);
      if (ta) axi_in.arvalid <= 1'b0;
      if (tw) axi_in.awvalid <= 1'b0;
      if (tv) axi_in.wvalid <= 1'b0;
      if (tb) begin
        axi_in.rready <= 1'b0;
        axi_in.bready <= 1'b0;
        break;
      end
    end
    if (i == 100) begin
      chk("bus timeout", 0, 1);
      end_of_test;
    end
  endtask

  // Oldest note is compared when an answer is accepted
  always @(negedge clk_sys) begin
    if ((axi_out.rvalid && axi_in.rready) || (axi_out.bvalid && axi_in.bready)) begin
      e = exq.pop_front();
      if (e[34]) chk("rdata", axi_out.rdata, e[31:0]);
      chk("resp", e[34] ? axi_out.rresp : axi_out.bresp, {30'h0, e[33:32]});
    end
  end

  task automatic wt(input logic s, input logic lvl);
    int i;
    for (i = 0; i < 6000; i++) begin
      @(negedge clk_sys);
      if ((s ? pix_out.strobe : pix_out.frame_active) === lvl) break;
    end
    if (i == 6000) begin
      chk("wait timeout", 0, 1);
      end_of_test;
    end
  endtask

  task automatic defaults;
    bus(1'b1, `ISR_ADDR_CTRL, 32'h0, `ISR_RESP_OKAY);
    bus(1'b1, `ISR_ADDR_WIDTH, {20'h0, `ISR_DEF_WIDTH}, `ISR_RESP_OKAY);
    bus(1'b1, `ISR_ADDR_HEIGHT, {20'h0, `ISR_DEF_HEIGHT}, `ISR_RESP_OKAY);
    bus(1'b1, `ISR_ADDR_HBLANK, {20'h0, `ISR_DEF_HBLANK}, `ISR_RESP_OKAY);
    bus(1'b1, `ISR_ADDR_VBLANK, {20'h0, `ISR_DEF_VBLANK}, `ISR_RESP_OKAY);
    bus(1'b1, `ISR_ADDR_EXPOSE, {20'h0, `ISR_DEF_EXPOSE}, `ISR_RESP_OKAY);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    cyc(20);
    rst <= 1'b0;
    clr <= 1'b0;
    cyc(1);
    defaults();
    for (k = 0; k < 4; k++) begin
      a = 8'h1c + 8'(4 * ($unsigned($random(seed)) % 57));
      bus(1'b0, a, $random(seed), `ISR_RESP_SLVERR);
      bus(1'b1, a, 32'h0, `ISR_RESP_SLVERR);
    end
    slave_id_select_in <= 1'b1;
    cyc(5);
    chk("slave_id", slave_id, `ISR_ID_SEL_HIGH);
    slave_id_select_in <= 1'b0;
    out_disable_in <= 1'b1;
    cyc(5);
    chk("slave_id", slave_id, `ISR_ID_SEL_LOW);
    chk("pix_oe", pix_oe, 0);
    out_disable_in <= 1'b0;
    cyc(5);
    chk("pix_oe", pix_oe, 1);
    // Short geometry keeps each frame near two thousand cycles
    bus(1'b0, `ISR_ADDR_WIDTH, 32'h8, `ISR_RESP_OKAY);
    bus(1'b0, `ISR_ADDR_HBLANK, 32'h4, `ISR_RESP_OKAY);
    bus(1'b0, `ISR_ADDR_HEIGHT, 32'h4, `ISR_RESP_OKAY);
    bus(1'b0, `ISR_ADDR_VBLANK, 32'ha, `ISR_RESP_OKAY);
    bus(1'b0, `ISR_ADDR_EXPOSE, 32'h2, `ISR_RESP_OKAY);
    for (m = 0; m < 4; m++) begin
      bus(1'b0, `ISR_ADDR_CTRL, {24'h0, ctl[m]}, `ISR_RESP_OKAY);
      standby_n_in <= 1'b0;
      clr <= 1'b1;
      cyc(40);
      chk("frame_active", pix_out.frame_active, 0);
      standby_n_in <= 1'b1;
      clr <= 1'b0;
      cyc(40);
      trigger_in <= 1'b1;
      wt(1'b1, 1'b1);
      chk("frame_active", pix_out.frame_active, 0);
      if (m == 3) begin
        cyc(800);
        chk("strobe", pix_out.strobe, 1);
      end
      @(posedge clk_sys);
      trigger_in <= 1'b0;
      wt(1'b1, 1'b0);
      wt(1'b0, 1'b1);
      wt(1'b0, 1'b0);
      cyc(600);
      chk("valid pixels", n_valid, nexp[m]);
      chk("frames", n_frames, 1);
      chk("array kind", kind, 2'h0);
      if (m == 0) begin
        chk("first data", first_data, 12'hd90);
        chk("first colour", first_color, 0);
      end
    end
    reset_n_in <= 1'b0;
    cyc(6);
    reset_n_in <= 1'b1;
    cyc(6);
    defaults();
    end_of_test;
  end
endmodule // isr_pixel_readout_tb
`default_nettype wire
